// ==== src/adcsr_pkg.sv ====
/*
  shared constants, register map and carrier types of the converter
  sequencer; assumes a 20 MHz pclk and a 32-bit apb register bus
*/
package adcsr_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned INSTR_CYCLE_NS = 200;
  localparam int unsigned INSTR_CYC = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TAD_DIV = 32;
  // converter geometry: 10 bits, 1024 steps
  localparam int unsigned RES_W = 10;
  localparam int unsigned RES_STEPS = 1024;
  localparam int unsigned CHAN_W = 3;
  // register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RES_HIGH = 8'h08;
  localparam logic [7:0] OFS_RES_LOW = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // control fields
  localparam int unsigned CTRL_ON_BIT = 0;
  localparam int unsigned CTRL_GO_BIT = 1;
  localparam int unsigned CTRL_RC_BIT = 2;
  localparam int unsigned CTRL_CHAN_LSB = 4;
  // status fields
  localparam int unsigned STAT_ACTIVE_BIT = 0;
  localparam int unsigned STAT_SLEEP_BIT = 1;
  localparam int unsigned STAT_WAKE_BIT = 2;
  // event bits
  localparam int unsigned EV_W = 2;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_ABORT = 1;
  localparam logic [EV_W-1:0] EV_RESET = 2'h0;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic rc_sel;
    logic go;
    logic conv_on;
  } adcsr_ctrl_t;

  localparam adcsr_ctrl_t CTRL_RESET = '{chan: 3'h0, rc_sel: 1'b0, go: 1'b0, conv_on: 1'b0};

  typedef enum logic [1:0] {
    ADCSR_IDLE = 2'b00,
    ADCSR_DELAY = 2'b01,
    ADCSR_CONV = 2'b10
  } adcsr_state_t;
endpackage

// ==== src/adcsr_tick_gen.sv ====
/*
  conversion step tick: divided pclk or edges of the synchronised rc
  oscillator; assumes rc_level already passed two flip-flops
*/
`timescale 1ns/1ns
module adcsr_tick_gen #(
  // four or more keeps divided steps behind the comparator path
  parameter int unsigned DIV = adcsr_pkg::TAD_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // source
  input wire logic rc_sel,
  input wire logic rc_level,
  input wire logic run,
  // step
  output logic tick
);
  import adcsr_pkg::*;
  localparam int unsigned CW = $clog2(DIV);
  // dac register plus two comparator flops settle before an rc step
  localparam int unsigned SETTLE = 3;
  localparam int unsigned SW = $clog2(SETTLE + 1);
  logic [CW-1:0] div_cnt;
  logic [SW-1:0] settle_cnt;
  logic rc_prev;

  // rc edges come at any phase, so hold them off until the trial settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= '0;
    end else if (!run || tick) begin
      settle_cnt <= '0;
    end else if (settle_cnt != SW'(SETTLE)) begin
      settle_cnt <= settle_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_prev <= 1'b0;
    end else begin
      rc_prev <= rc_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (!run || div_cnt == CW'(DIV - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
    end else if (rc_sel) begin
      tick <= run && rc_level && !rc_prev && !tick && settle_cnt == SW'(SETTLE); // see R2
    end else begin
      tick <= run && div_cnt == CW'(DIV - 1);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tick_single_pulse: assert property (!rc_sel && $past(!rc_sel) && tick |=> !tick) // see R2
    else $error("divided tick lasted more than one cycle");
  a_tick_needs_run: assert property (!run |=> !tick) // see R2
    else $error("tick while conversion not running");
endmodule

// ==== src/adcsr_sar.sv ====
/*
  successive approximation engine: one result bit per tick, msb first;
  assumes cmp_level is synchronised and high when input >= trial code
*/
`timescale 1ns/1ns
module adcsr_sar #(
  parameter int unsigned W = adcsr_pkg::RES_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  input wire logic cmp_level,
  // result
  output logic busy,
  output logic done,
  output logic [W-1:0] trial,
  output logic [W-1:0] result
);
  import adcsr_pkg::*;
  logic [W-1:0] bit_ptr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      bit_ptr <= '0;
      trial <= '0;
      result <= '0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
        bit_ptr <= '0;
      end else if (start) begin
        busy <= 1'b1;
        bit_ptr <= {1'b1, {(W-1){1'b0}}};
        trial <= {1'b1, {(W-1){1'b0}}};
      end else if (busy && tick) begin
        // keep the trial bit if the input is at or above it
        if (bit_ptr[0]) begin
          busy <= 1'b0;
          done <= 1'b1;
          result <= cmp_level ? trial : (trial & ~bit_ptr);
        end else begin
          trial <= (cmp_level ? trial : (trial & ~bit_ptr)) | (bit_ptr >> 1);
        end
        bit_ptr <= bit_ptr >> 1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sar_done_end: assert property (done |-> $past(busy) && !busy) // see R2
    else $error("done without a running conversion");
  a_sar_abort_stop: assert property (abort |=> !busy && !done) // see R2
    else $error("engine kept running after abort");
endmodule

// ==== src/adcsr_top.sv ====
/*
  converter sequencer: apb registers, start ordering, sleep and reset
  behaviour, result registers and interrupt; assumes the core drives
  sleep_req while sleeping and the analog comparator and rc oscillator
  arrive from outside the pclk domain
*/
// Our own choices: register access over APB and the placing of the registers.
// Overview of operation
// R1: software waits the acquisition time after a channel change before starting.
// R2: conversions run during sleep only with the rc oscillator as step clock.
// R3: with rc clock selected, start waits one instruction cycle after the go request.
// R4: on completion go clears and the result loads into high and low bytes.
// R5: completion during sleep with the interrupt enabled wakes the device.
// R6: completion during sleep, interrupt disabled: module powers off, converter-on stays set.
// R7: sleep with a non-rc clock aborts conversion, powers off, converter-on stays set.
// R8: device reset restores control registers, powers off, aborts pending conversion.
// R9: device reset leaves the high and low result registers unchanged.
// R10: module-active status reads 1 while operating, 0 while shut off.
// R11: result bytes update in the same cycle that go clears.
`timescale 1ns/1ns
module adcsr_top #(
  parameter int unsigned DIV = adcsr_pkg::TAD_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core
  input wire logic sleep_req,
  output logic wake,
  output logic irq,
  // analog front end
  input wire logic rc_osc,
  input wire logic cmp_in,
  output logic [adcsr_pkg::CHAN_W-1:0] chan_sel,
  output logic hold_capacitor,
  output logic [adcsr_pkg::RES_W-1:0] dac_code,
  output logic module_active
);
  import adcsr_pkg::*;

  adcsr_ctrl_t ctrl;
  adcsr_state_t state;
  logic [2:0] delay_cnt;
  logic [RES_W-1:0] result;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] irq_mask;
  logic shut_off;
  logic rc_meta, rc_sync, cmp_meta, cmp_sync;
  logic tick, sar_busy, sar_done;
  logic [RES_W-1:0] sar_trial, sar_result;

  // apb decode
  logic apb_acc, apb_wr, wr_ctrl;
  assign apb_acc = psel && penable && pready;
  assign apb_wr = apb_acc && pwrite;
  assign wr_ctrl = apb_wr && paddr == OFS_CTRL;

  function automatic logic addr_mapped(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_STATUS || a == OFS_RES_HIGH ||
           a == OFS_RES_LOW || a == OFS_IRQ_STAT || a == OFS_IRQ_MASK;
  endfunction

  // sequencing conditions
  logic go_start, abort_sleep, abort_sw, abort, sar_start, delay_end;
  assign go_start = wr_ctrl && pwdata[CTRL_GO_BIT] && pwdata[CTRL_ON_BIT] &&
                    ctrl.conv_on && state == ADCSR_IDLE && !shut_off;
  assign abort_sleep = sleep_req && !ctrl.rc_sel && state != ADCSR_IDLE; // see R2 see R7
  assign abort_sw = wr_ctrl && (!pwdata[CTRL_GO_BIT] || !pwdata[CTRL_ON_BIT]);
  assign abort = state != ADCSR_IDLE && (abort_sleep || abort_sw);
  assign delay_end = state == ADCSR_DELAY && delay_cnt == 3'(INSTR_CYC - 1);
  assign sar_start = !abort && (delay_end || (go_start && !ctrl.rc_sel));

  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_meta <= 1'b0;
      rc_sync <= 1'b0;
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      rc_meta <= rc_osc;
      rc_sync <= rc_meta;
      cmp_meta <= cmp_in;
      cmp_sync <= cmp_meta;
    end
  end

  adcsr_tick_gen #(.DIV(DIV)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .rc_sel(ctrl.rc_sel),
    .rc_level(rc_sync),
    .run(sar_busy),
    .tick(tick)
  );

  adcsr_sar #(.W(RES_W)) u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .start(sar_start),
    .abort(abort),
    .tick(tick),
    .cmp_level(cmp_sync),
    .busy(sar_busy),
    .done(sar_done),
    .trial(sar_trial),
    .result(sar_result)
  );

  // conversion sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ADCSR_IDLE; // see R8
      delay_cnt <= 3'h0;
    end else begin
      case (state)
        ADCSR_IDLE: begin
          delay_cnt <= 3'h0;
          if (go_start) begin
            state <= ctrl.rc_sel ? ADCSR_DELAY : ADCSR_CONV; // see R3
          end
        end
        ADCSR_DELAY: begin
          if (abort) begin
            state <= ADCSR_IDLE;
          end else if (delay_end) begin
            state <= ADCSR_CONV; // see R3
          end else begin
            delay_cnt <= delay_cnt + 3'h1;
          end
        end
        ADCSR_CONV: begin
          if (abort || sar_done) begin
            state <= ADCSR_IDLE; // see R7
          end
        end
        default: state <= ADCSR_IDLE;
      endcase
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET; // see R8
    end else begin
      if (wr_ctrl) begin
        ctrl.conv_on <= pwdata[CTRL_ON_BIT];
        if (state == ADCSR_IDLE) begin
          ctrl.rc_sel <= pwdata[CTRL_RC_BIT];
          ctrl.chan <= pwdata[CTRL_CHAN_LSB +: CHAN_W];
        end
      end
      if (go_start) begin
        ctrl.go <= 1'b1;
      end else if (sar_done || abort) begin
        ctrl.go <= 1'b0; // see R4
      end else if (wr_ctrl && !pwdata[CTRL_GO_BIT]) begin
        ctrl.go <= 1'b0;
      end
    end
  end

  // result pair, kept across reset
  always_ff @(posedge pclk) begin
    if (sar_done) begin
      result <= sar_result; // see R4 see R9 see R11
    end
  end

  // sleep power-down and wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shut_off <= 1'b0;
      wake <= 1'b0;
    end else begin
      if (sar_done && sleep_req && !irq_mask[EV_DONE]) begin
        shut_off <= 1'b1; // see R6
      end else if (sleep_req && !ctrl.rc_sel && ctrl.conv_on) begin
        shut_off <= 1'b1; // see R7
      end else if (!sleep_req) begin
        shut_off <= 1'b0;
      end
      if (sar_done && sleep_req && irq_mask[EV_DONE]) begin
        wake <= 1'b1; // see R5
      end else if (!sleep_req) begin
        wake <= 1'b0;
      end
    end
  end

  // pin-facing outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_active <= 1'b0;
      hold_capacitor <= 1'b0;
      chan_sel <= '0;
      dac_code <= '0;
    end else begin
      module_active <= ctrl.conv_on && !shut_off; // see R10
      // sampling switch closed while idle so software can meet acquisition_time
      hold_capacitor <= ctrl.conv_on && !shut_off && state != ADCSR_CONV; // see R1
      chan_sel <= ctrl.chan;
      dac_code <= sar_trial;
    end
  end

  // interrupt status and mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= EV_RESET;
      irq_mask <= EV_RESET;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((apb_wr && paddr == OFS_IRQ_STAT) ? pwdata[EV_W-1:0] :
                  EV_RESET)) | {abort, sar_done};
      if (apb_wr && paddr == OFS_IRQ_MASK) begin
        irq_mask <= pwdata[EV_W-1:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // apb answer: one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_mapped(paddr);
      prdata <= 32'h0;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          OFS_CTRL: prdata[CTRL_CHAN_LSB+CHAN_W-1:0] <= {ctrl.chan, 1'b0, ctrl.rc_sel,
                                                         ctrl.go, ctrl.conv_on};
          OFS_STATUS: prdata[STAT_WAKE_BIT:0] <= {wake, sleep_req, module_active};
          OFS_RES_HIGH: prdata[RES_W-9:0] <= result[RES_W-1:8];
          OFS_RES_LOW: prdata[7:0] <= result[7:0];
          OFS_IRQ_STAT: prdata[EV_W-1:0] <= irq_stat;
          OFS_IRQ_MASK: prdata[EV_W-1:0] <= irq_mask;
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking

  sequence s_rc_wait;
    (!sar_start)[*3] ##1 (sar_start || state == ADCSR_IDLE);
  endsequence

  a_rc_start_delay: assert property (disable iff (!presetn) // see R3
    go_start && ctrl.rc_sel |=> s_rc_wait)
    else $error("rc start not delayed by one instruction cycle");
  a_fast_start: assert property (disable iff (!presetn) // see R3
    go_start && !ctrl.rc_sel && !abort |-> sar_start)
    else $error("non-rc conversion did not start at once");
  a_done_loads: assert property (disable iff (!presetn) // see R4
    sar_done && !go_start |=> !ctrl.go && result == $past(sar_result))
    else $error("go not cleared or result not loaded on completion");
  a_sleep_abort: assert property (disable iff (!presetn) // see R7
    abort_sleep |=> state == ADCSR_IDLE && !ctrl.go && !sar_busy)
    else $error("sleep with non-rc clock did not abort");
  a_sleep_off: assert property (disable iff (!presetn) // see R7
    sleep_req && !ctrl.rc_sel && ctrl.conv_on && !wr_ctrl |=> ctrl.conv_on ##1 !module_active)
    else $error("module not powered off in sleep or converter-on lost");
  a_wake_irq_on: assert property (disable iff (!presetn) // see R5
    sar_done && sleep_req && irq_mask[EV_DONE] |=> wake)
    else $error("no wake on completion in sleep");
  a_sleep_done_off: assert property (disable iff (!presetn) // see R6
    sar_done && sleep_req && !irq_mask[EV_DONE] |=> shut_off ##1 !module_active)
    else $error("module stayed on after completion in sleep");
  a_rc_keeps_running: assert property (disable iff (!presetn) // see R2
    state == ADCSR_CONV && sleep_req && ctrl.rc_sel && !abort_sw && !sar_done |=>
    state == ADCSR_CONV)
    else $error("rc conversion stopped during sleep");
  a_reset_values: assert property ($rose(presetn) |-> state == ADCSR_IDLE && // see R8
    !ctrl.conv_on && !ctrl.go && !module_active)
    else $error("control state not at reset value");
  a_result_same_cycle: assert property (disable iff (!presetn) // see R11
    ctrl.go ##1 !ctrl.go && state == ADCSR_IDLE && $past(sar_done) |->
    result == $past(sar_result))
    else $error("result and go flag changed in different cycles");
  a_active_status: assert property (disable iff (!presetn) // see R10
    ##1 module_active == $past(ctrl.conv_on && !shut_off))
    else $error("active status wrong");
  a_irq_level: assert property (disable iff (!presetn)
    |(irq_stat & irq_mask) |=> irq)
    else $error("interrupt not raised");
endmodule

// ==== tb/adcsr_afe_model.sv ====
/*
  analog front end model: free-running rc oscillator and an ideal
  comparator against a held input level; assumes dac_code from the dut
*/
`timescale 1ns/1ns
module adcsr_afe_model (
  // analog level and trial code
  input wire logic [9:0] vin,
  input wire logic [9:0] dac_code,
  // outputs to the converter
  output logic rc_osc,
  output logic cmp_in
);
  // rc runs free, unrelated to pclk, slower than the comparator path
  initial rc_osc = 1'b0;
  always #130 rc_osc = ~rc_osc;
  assign cmp_in = (vin >= dac_code);
endmodule

// ==== tb/test_adcsr_top.sv ====
/*
  self-checking bench: apb tasks drive the sequencer through normal,
  sleep and reset cases; assumes adcsr_top and the front end model
*/
`timescale 1ns/1ns
module test_adcsr_top;
  import adcsr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sleep_req = 1'b0;
  logic wake;
  logic irq;
  logic rc_osc;
  logic cmp_in;
  logic [CHAN_W-1:0] chan_sel;
  logic hold_capacitor;
  logic [RES_W-1:0] dac_code;
  logic module_active;
  logic [9:0] vin = 10'h000;
  logic [31:0] q;
  logic err;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  always #25 pclk = ~pclk;

  adcsr_top #(.DIV(4)) adcsr_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .wake(wake),
    .irq(irq), .rc_osc(rc_osc), .cmp_in(cmp_in), .chan_sel(chan_sel),
    .hold_capacitor(hold_capacitor), .dac_code(dac_code),
    .module_active(module_active)
  );

  adcsr_afe_model adcsr_afe_model_inst (
    .vin(vin), .dac_code(dac_code), .rc_osc(rc_osc), .cmp_in(cmp_in)
  );

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      check(1'b0, 1'b1, "pready wait");
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp, "read");
  endtask

  task automatic wait_idle();
    int n;
    for (n = 0; n < 100; n++) begin
      apb(1'b0, OFS_CTRL, 32'h0);
      if (q[CTRL_GO_BIT] === 1'b0) begin
        break;
      end
    end
    check(q[CTRL_GO_BIT], 1'b0, "go clears");
  endtask

  task automatic result_is(input logic [9:0] v);
    rd(OFS_RES_HIGH, {30'h0, v[9:8]});
    rd(OFS_RES_LOW, {24'h0, v[7:0]});
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h0);
    rd(8'h18, 32'h0);
    check(err, 1'b1, "unmapped");
    // plain conversion, pclk steps, interrupt on
    apb(1'b1, OFS_CTRL, 32'h31);
    rd(OFS_STATUS, 32'h1);
    check(chan_sel, 3'h3, "chan");
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    vin <= 10'h2a5;
    repeat (40) @(posedge pclk);
    apb(1'b1, OFS_CTRL, 32'h33);
    wait_idle();
    result_is(10'h2a5);
    rd(OFS_IRQ_STAT, 32'h1);
    check(irq, 1'b1, "irq up");
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    rd(OFS_IRQ_STAT, 32'h0);
    check(irq, 1'b0, "irq down");
    // sleep with pclk steps aborts
    apb(1'b1, OFS_CTRL, 32'h33);
    sleep_req <= 1'b1;
    repeat (4) @(posedge pclk);
    check(module_active, 1'b0, "abort off");
    rd(OFS_CTRL, 32'h31);
    rd(OFS_IRQ_STAT, 32'h2);
    sleep_req <= 1'b0;
    apb(1'b1, OFS_IRQ_STAT, 32'h3);
    result_is(10'h2a5);
    // rc steps in sleep, interrupt wakes
    apb(1'b1, OFS_CTRL, 32'h35);
    vin <= 10'h15a;
    repeat (40) @(posedge pclk);
    apb(1'b1, OFS_CTRL, 32'h37);
    sleep_req <= 1'b1;
    repeat (2) @(posedge pclk);
    check(hold_capacitor, 1'b1, "start held");
    repeat (8) @(posedge pclk);
    check(hold_capacitor, 1'b0, "started");
    for (int n = 0; n < 400 && wake !== 1'b1; n++) @(posedge pclk);
    check(wake, 1'b1, "wake");
    wait_idle();
    result_is(10'h15a);
    sleep_req <= 1'b0;
    repeat (3) @(posedge pclk);
    check(wake, 1'b0, "wake down");
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    // rc steps in sleep, interrupt masked
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    vin <= 10'h3ff;
    repeat (40) @(posedge pclk);
    apb(1'b1, OFS_CTRL, 32'h37);
    sleep_req <= 1'b1;
    wait_idle();
    result_is(10'h3ff);
    rd(OFS_CTRL, 32'h35);
    check(module_active, 1'b0, "masked off");
    check(wake, 1'b0, "no wake");
    check(irq, 1'b0, "masked irq");
    sleep_req <= 1'b0;
    // reset during a conversion
    apb(1'b1, OFS_CTRL, 32'h31);
    vin <= 10'h0c3;
    apb(1'b1, OFS_CTRL, 32'h33);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(module_active, 1'b0, "reset off");
    presetn <= 1'b1;
    rd(OFS_CTRL, 32'h0);
    repeat (40) @(posedge pclk);
    rd(OFS_IRQ_STAT, 32'h0);
    result_is(10'h3ff);
    close_out();
  end
endmodule
